// ==== src/flash_host_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - high-voltage id read with fixed low lines
// - protect: drive at high voltage, strobe pulse
// - word mode unlock addresses 555h, 2AAh
// - byte mode unlock addresses AAAh, 555h
module flash_host_ctrl
   import flash_host_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire logic unprotect_en,
   output logic cmd_ready_r,
   output logic rsp_valid_r,
   output logic rsp_err_r,
   output logic [7:0] rsp_data_r,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [ADDR_W-2:0] flash_addr,
   output logic top_data_pin,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   input wire logic [7:0] dq_in,
   output logic byte_sel_n_r,
   output logic reset_n_r,
   output logic hv_reset_r,
   output logic hv_a9_r,
   output logic hv_oe,
   input wire logic done_flag_pin
);
   typedef enum {ST_IDLE, ST_CYCLE, ST_WAIT, ST_BUSY, ST_RESET} st_e;

   st_e st_r, st_nxt;
   op_e op_r, op_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [7:0] data_r, data_nxt;
   logic [2:0] step_r, step_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic cmd_ready_nxt, rsp_valid_nxt, rsp_err_nxt, reset_n_nxt, hv_a9_nxt;
   logic [7:0] rsp_data_nxt;
   logic done_s1_r, done_s2_r;
   logic go, eng_done;
   logic [7:0] eng_rdata;
   logic [ADDR_W-1:0] eng_addr;
   logic [2:0] n_steps;
   logic s_rd, s_hv, s_hv_oe, goes_busy;
   logic [ADDR_W-1:0] s_addr;
   logic [7:0] s_data;
   logic legal;

   // ------------------------------------------------------------
   // pin synchroniser and level pins
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         done_s1_r <= 1'b0;
         done_s2_r <= 1'b0;
         byte_sel_n_r <= 1'b1;
         hv_reset_r <= 1'b0;
      end else begin
         done_s1_r <= done_flag_pin;
         done_s2_r <= done_s1_r;
         byte_sel_n_r <= 1'b0;
         hv_reset_r <= unprotect_en;
      end
   end

   // ------------------------------------------------------------
   // step table for the current command
   // ------------------------------------------------------------
   always_comb begin
      n_steps = 3'd1;
      s_rd = 1'b0;
      s_hv = 1'b0;
      s_hv_oe = 1'b0;
      s_addr = addr_r;
      s_data = data_r;
      goes_busy = 1'b0;
      // unlock pairs open every multi-write command, again at steps 3,4 of an erase
      if (step_r == 3'd0 || (step_r == 3'd3 && (op_r == OP_CHIP_ERASE || op_r == OP_SECTOR_ERASE))) begin
         s_addr = UNLOCK1_ADDR;
         s_data = D_UNLOCK1;
      end else if (step_r == 3'd1 || step_r == 3'd4) begin
         s_addr = UNLOCK2_ADDR;
         s_data = D_UNLOCK2;
      end else begin
         s_addr = UNLOCK1_ADDR;
      end
      unique case (op_r)
         OP_READ: begin
            s_rd = 1'b1;
            s_addr = addr_r;
         end
         OP_RESET_SHORT: begin
            s_addr = addr_r;
            s_data = D_RESET;
         end
         OP_RESET_LONG: begin
            n_steps = 3'd3;
            if (step_r == 3'd2) s_data = D_RESET;
         end
         OP_ID_CMD: begin
            n_steps = 3'd5;
            if (step_r == 3'd2) s_data = D_ID;
            if (step_r == 3'd3) begin
               s_rd = 1'b1;
               s_addr = addr_r;
            end
            if (step_r == 3'd4) s_data = D_RESET;
         end
         OP_PROGRAM: begin
            n_steps = 3'd4;
            goes_busy = 1'b1;
            if (step_r == 3'd2) s_data = D_PROG;
            if (step_r == 3'd3) begin
               s_addr = addr_r;
               s_data = data_r;
            end
         end
         OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
            n_steps = 3'd6;
            goes_busy = 1'b1;
            if (step_r == 3'd2) s_data = D_ERASE;
            if (step_r == 3'd5) begin
               if (op_r == OP_CHIP_ERASE) begin
                  s_data = D_CHIP;
               end else begin
                  s_addr = {addr_r[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
                  s_data = D_SECTOR;
               end
            end
         end
         OP_SUSPEND: begin
            s_addr = addr_r;
            s_data = D_SUSPEND;
         end
         OP_RESUME: begin
            s_addr = addr_r;
            s_data = D_RESUME;
            goes_busy = 1'b1;
         end
         OP_ID_HV: begin
            s_rd = 1'b1;
            s_hv = 1'b1;
            s_addr = '0;
            s_addr[A0_BIT] = addr_r[A0_BIT];
            s_addr[A9_BIT] = 1'b1;
         end
         OP_PROT_VERIFY, OP_PROT_ENABLE: begin
            s_rd = (op_r == OP_PROT_VERIFY);
            s_hv = 1'b1;
            s_hv_oe = (op_r == OP_PROT_ENABLE);
            s_addr = {addr_r[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
            s_addr[A1_BIT] = 1'b1;
            s_addr[A9_BIT] = 1'b1;
         end
         OP_HW_RESET: begin
            n_steps = 3'd1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   assign legal = (cmd_op <= 4'(OP_HW_RESET));

   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      step_nxt = step_r;
      cnt_nxt = cnt_r;
      cmd_ready_nxt = cmd_ready_r;
      rsp_valid_nxt = 1'b0;
      rsp_err_nxt = rsp_err_r;
      rsp_data_nxt = rsp_data_r;
      reset_n_nxt = reset_n_r;
      hv_a9_nxt = hv_a9_r;
      go = 1'b0;
      unique case (st_r)
         ST_IDLE, ST_BUSY: begin
            if (st_r == ST_BUSY) begin
               cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
               if (cnt_r == 16'h0000 && done_s2_r) begin
                  // the device is back in read mode by itself
                  st_nxt = ST_IDLE;
                  rsp_valid_nxt = 1'b1;
                  rsp_err_nxt = 1'b0;
               end
            end
            if (cmd_valid && cmd_ready_r) begin
               // only a suspend may interrupt a running sector erase
               if (!legal || (st_r == ST_BUSY && op_e'(cmd_op) != OP_SUSPEND)) begin
                  rsp_valid_nxt = 1'b1;
                  rsp_err_nxt = 1'b1;
               end else begin
                  op_nxt = op_e'(cmd_op);
                  addr_nxt = cmd_addr;
                  data_nxt = cmd_data;
                  step_nxt = 3'd0;
                  cmd_ready_nxt = 1'b0;
                  rsp_valid_nxt = 1'b0;
                  if (op_e'(cmd_op) == OP_HW_RESET) begin
                     st_nxt = ST_RESET;
                     reset_n_nxt = 1'b0;
                     cnt_nxt = 16'(RP_CYC);
                  end else begin
                     st_nxt = ST_CYCLE;
                  end
               end
            end else if (st_r == ST_BUSY) begin
               cmd_ready_nxt = (op_r == OP_SECTOR_ERASE || op_r == OP_RESUME);
            end
         end
         ST_CYCLE: begin
            go = 1'b1;
            hv_a9_nxt = s_hv;
            st_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            if (eng_done) begin
               if (s_rd) rsp_data_nxt = eng_rdata;
               if (step_r == n_steps - 3'd1) begin
                  hv_a9_nxt = 1'b0;
                  rsp_err_nxt = 1'b0;
                  if (goes_busy) begin
                     st_nxt = ST_BUSY;
                     cnt_nxt = 16'(BUSY_CYC);
                     cmd_ready_nxt = 1'b0;
                  end else begin
                     st_nxt = ST_IDLE;
                     cmd_ready_nxt = 1'b1;
                     rsp_valid_nxt = 1'b1;
                  end
               end else begin
                  step_nxt = step_r + 3'd1;
                  st_nxt = ST_CYCLE;
               end
            end
         end
         ST_RESET: begin
            cnt_nxt = cnt_r - 16'h0001;
            if (cnt_r == 16'h0001) begin
               if (!reset_n_r) begin
                  reset_n_nxt = 1'b1;
                  cnt_nxt = 16'(RH_CYC);
               end else begin
                  st_nxt = ST_IDLE;
                  cmd_ready_nxt = 1'b1;
                  rsp_valid_nxt = 1'b1;
                  rsp_err_nxt = 1'b0;
               end
            end
         end
      endcase
      if (st_r == ST_BUSY && st_nxt == ST_IDLE) cmd_ready_nxt = 1'b1;
      // ready and the device reset pin rise one edge after reset release
      if (st_r == ST_IDLE && !reset_n_r) begin
         cmd_ready_nxt = 1'b1;
         reset_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= ST_IDLE;
         op_r <= OP_READ;
         addr_r <= '0;
         data_r <= 8'h00;
         step_r <= 3'd0;
         cnt_r <= 16'h0000;
         cmd_ready_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_err_r <= 1'b0;
         rsp_data_r <= 8'h00;
         reset_n_r <= 1'b0;
         hv_a9_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         step_r <= step_nxt;
         cnt_r <= cnt_nxt;
         cmd_ready_r <= cmd_ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_err_r <= rsp_err_nxt;
         rsp_data_r <= rsp_data_nxt;
         reset_n_r <= reset_n_nxt;
         hv_a9_r <= hv_a9_nxt;
      end
   end

   flash_bus_cycle u_cycle (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .go(go),
      .rd(s_rd),
      .hv_oe(s_hv_oe),
      .addr(s_addr),
      .wdata(s_data),
      .dq_in(dq_in),
      .done_r(eng_done),
      .rdata_r(eng_rdata),
      .ce_n_r(flash_ce_n),
      .oe_n_r(flash_oe_n),
      .we_n_r(flash_we_n),
      .oe_hv_r(hv_oe),
      .addr_r(eng_addr),
      .dq_out_r(dq_out),
      .dq_oe_n_r(dq_oe_n)
   );
   assign flash_addr = eng_addr[ADDR_W-1:1];
   assign top_data_pin = eng_addr[A_M1_BIT];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_byte_mode_held: assert property (##1 1'b1 |-> !byte_sel_n_r)
      else $error("byte mode not selected");
   a_unlock_addr: assert property (!flash_we_n && op_r == OP_PROGRAM && step_r == 3'd1
      |-> eng_addr == UNLOCK2_ADDR && dq_out == D_UNLOCK2)
      else $error("second unlock write wrong");
   a_sector_bits: assert property (!flash_we_n && op_r == OP_SECTOR_ERASE && step_r == 3'd5
      |-> eng_addr[SECT_LSB-1:0] == '0 && dq_out == D_SECTOR)
      else $error("sector erase address or data wrong");
   a_hv_id_read: assert property (!flash_oe_n && hv_a9_r && op_r == OP_ID_HV
      |-> !eng_addr[A1_BIT] && !eng_addr[A6_BIT] && !eng_addr[A_M1_BIT] && flash_we_n)
      else $error("high-voltage id read with bad address lines");
   a_prot_enable: assert property (hv_oe |-> flash_oe_n && hv_a9_r && eng_addr[A1_BIT] && !eng_addr[A0_BIT])
      else $error("protect enable pins wrong");
   a_prot_verify: assert property (!flash_oe_n && op_r == OP_PROT_VERIFY
      |-> hv_a9_r && eng_addr[A1_BIT] && !eng_addr[A0_BIT] && !eng_addr[A6_BIT])
      else $error("protect verify pins wrong");
   a_unprotect_level: assert property (unprotect_en |=> hv_reset_r)
      else $error("unprotect level not forwarded");
   a_dq_released: assert property (!reset_n_r || flash_ce_n || !flash_oe_n |-> dq_oe_n)
      else $error("data pins driven outside a write");
   a_busy_no_resp: assert property (st_r == ST_BUSY && cnt_r != 16'h0000 |=> !rsp_valid_r || rsp_err_r)
      else $error("completion reported before busy window");
   a_id_cmd_data: assert property (!flash_we_n && op_r == OP_ID_CMD && step_r == 3'd2 |-> dq_out == D_ID)
      else $error("identification command data wrong");

   c_program: cover property (op_r == OP_PROGRAM && st_r == ST_BUSY ##[1:300] rsp_valid_r);
   c_sector_erase: cover property (op_r == OP_SECTOR_ERASE && st_r == ST_BUSY);
   c_suspend: cover property (op_r == OP_SUSPEND && rsp_valid_r);
   c_hw_reset: cover property ($rose(reset_n_r));
endmodule : flash_host_ctrl

// ==== src/flash_host_pkg.sv ====
package flash_host_pkg;
   // ------------------------------------------------------------
   // clock and pin timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_AS_NS = 20;    // address setup before the strobe
   localparam int T_WP_NS = 60;    // write strobe low time
   localparam int T_DH_NS = 20;    // address and data hold after the strobe
   localparam int T_ACC_NS = 120;  // output access time
   localparam int T_RP_NS = 500;   // hardware reset low time
   localparam int T_RH_NS = 200;   // recovery after hardware reset
   localparam int T_BUSY_NS = 90;  // time before done flag is trusted
   // least times, rounded up to whole cycles
   localparam int AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DH_CYC = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_CYC = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_CYC = 2;

   // ------------------------------------------------------------
   // byte address layout: bit 0 is the top data pin as lowest address
   // ------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int A_M1_BIT = 0;
   localparam int A0_BIT = 1;
   localparam int A1_BIT = 2;
   localparam int A6_BIT = 7;
   localparam int A9_BIT = 10;
   localparam int SECT_LSB = 13;
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 20'h0_0AAA;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 20'h0_0555;

   // ------------------------------------------------------------
   // command data
   // ------------------------------------------------------------
   localparam logic [7:0] D_UNLOCK1 = 8'hAA;
   localparam logic [7:0] D_UNLOCK2 = 8'h55;
   localparam logic [7:0] D_RESET = 8'hF0;
   localparam logic [7:0] D_ID = 8'h90;
   localparam logic [7:0] D_PROG = 8'hA0;
   localparam logic [7:0] D_ERASE = 8'h80;
   localparam logic [7:0] D_CHIP = 8'h10;
   localparam logic [7:0] D_SECTOR = 8'h30;
   localparam logic [7:0] D_SUSPEND = 8'hB0;
   localparam logic [7:0] D_RESUME = 8'h30;

   typedef enum logic [3:0] {
      OP_READ, OP_RESET_SHORT, OP_RESET_LONG, OP_ID_CMD, OP_PROGRAM,
      OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_ID_HV,
      OP_PROT_VERIFY, OP_PROT_ENABLE, OP_HW_RESET
   } op_e;
endpackage : flash_host_pkg

// ==== src/flash_bus_cycle.sv ====
`timescale 1ns/1ps
module flash_bus_cycle
   import flash_host_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic go,
   input wire logic rd,
   input wire logic hv_oe,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] dq_in,
   output logic done_r,
   output logic [7:0] rdata_r,
   output logic ce_n_r,
   output logic oe_n_r,
   output logic we_n_r,
   output logic oe_hv_r,
   output logic [ADDR_W-1:0] addr_r,
   output logic [7:0] dq_out_r,
   output logic dq_oe_n_r
);
   typedef enum {ENG_IDLE, ENG_SETUP, ENG_PULSE, ENG_HOLD} eng_e;

   eng_e st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic rd_r, rd_nxt;
   logic done_nxt, ce_n_nxt, oe_n_nxt, we_n_nxt, oe_hv_nxt, dq_oe_n_nxt;
   logic [ADDR_W-1:0] addr_nxt;
   logic [7:0] dq_out_nxt, rdata_nxt;
   logic [7:0] dq_s1_r, dq_s2_r;

   // ------------------------------------------------------------
   // data pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
      end else begin
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   // ------------------------------------------------------------
   // one bus cycle
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      rd_nxt = rd_r;
      done_nxt = 1'b0;
      ce_n_nxt = ce_n_r;
      oe_n_nxt = oe_n_r;
      we_n_nxt = we_n_r;
      oe_hv_nxt = oe_hv_r;
      addr_nxt = addr_r;
      dq_out_nxt = dq_out_r;
      dq_oe_n_nxt = dq_oe_n_r;
      rdata_nxt = rdata_r;
      unique case (st_r)
         ENG_IDLE: begin
            if (go) begin
               st_nxt = ENG_SETUP;
               cnt_nxt = 8'(AS_CYC);
               rd_nxt = rd;
               ce_n_nxt = 1'b0;
               addr_nxt = addr;
               dq_out_nxt = wdata;
               dq_oe_n_nxt = rd;
               oe_hv_nxt = hv_oe && !rd;
            end
         end
         ENG_SETUP: begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               st_nxt = ENG_PULSE;
               // a read keeps the write strobe high, a write keeps output drive high
               oe_n_nxt = !rd_r;
               we_n_nxt = rd_r;
               // sampled data passes the synchroniser, so the read waits it out
               cnt_nxt = rd_r ? 8'(ACC_CYC + SYNC_CYC) : 8'(WP_CYC);
            end
         end
         ENG_PULSE: begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               st_nxt = ENG_HOLD;
               cnt_nxt = 8'(DH_CYC);
               we_n_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               if (rd_r) begin
                  rdata_nxt = dq_s2_r;
               end
            end
         end
         ENG_HOLD: begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               st_nxt = ENG_IDLE;
               done_nxt = 1'b1;
               ce_n_nxt = 1'b1;
               dq_oe_n_nxt = 1'b1;
               oe_hv_nxt = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= ENG_IDLE;
         cnt_r <= 8'h00;
         rd_r <= 1'b0;
         done_r <= 1'b0;
         ce_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         we_n_r <= 1'b1;
         oe_hv_r <= 1'b0;
         addr_r <= '0;
         dq_out_r <= 8'h00;
         dq_oe_n_r <= 1'b1;
         rdata_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         done_r <= done_nxt;
         ce_n_r <= ce_n_nxt;
         oe_n_r <= oe_n_nxt;
         we_n_r <= we_n_nxt;
         oe_hv_r <= oe_hv_nxt;
         addr_r <= addr_nxt;
         dq_out_r <= dq_out_nxt;
         dq_oe_n_r <= dq_oe_n_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_write_oe_high: assert property (!we_n_r |-> oe_n_r)
      else $error("write strobe low while output drive low");
   a_addr_through_we: assert property (!we_n_r && $past(!we_n_r) |-> $stable(addr_r))
      else $error("address moved during write strobe");
   a_data_at_rise: assert property ($rose(we_n_r) |-> $stable(dq_out_r) && !dq_oe_n_r ##1 !dq_oe_n_r)
      else $error("write data not held across strobe rise");
endmodule : flash_bus_cycle

// ==== tb/flash_dev_model.sv ====
`timescale 1ns/1ps
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'hC5, // arbitrary value
   parameter int BUSY_T = 60
)(
   input wire logic clk,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [ADDR_W-2:0] addr,
   input wire logic top_data_pin,
   input wire logic [7:0] dq_out,
   input wire logic reset_n,
   input wire logic hv_reset,
   input wire logic hv_a9,
   input wire logic hv_oe,
   output logic [7:0] dq_in,
   output logic done_flag_pin
);
   // ------------------------------------------------------------
   // behavioural device: clk paces busy time, output refresh and clearing on the reset pin
   // ------------------------------------------------------------
   logic [7:0] mem [int];
   logic [127:0] prot = '0;
   logic [4:0][7:0] h = '0;
   logic [ADDR_W-1:0] wa;
   logic id_mode = 0;
   logic susp = 0;
   int busy = 0;
   wire [ADDR_W-1:0] a = {addr, top_data_pin};
   function automatic logic [7:0] rv();
      if (hv_a9 || id_mode)
         return a[A1_BIT] ? {7'h0, prot[a[ADDR_W-1:SECT_LSB]]} : (a[A0_BIT] ? PART_CODE : MAKER_CODE);
      return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
   endfunction : rv
   always @(negedge we_n) if (!ce_n) wa <= a;
   always @(posedge we_n) begin
      if (!ce_n && reset_n && hv_oe && hv_a9 && wa[A1_BIT]) prot[wa[ADDR_W-1:SECT_LSB]] = 1'b1;
      else if (!ce_n && reset_n && oe_n) begin
         // address bits above the unlock field are not compared by the unlock checks
         if (dq_out == D_RESET && h[2:0] != {D_UNLOCK1, D_UNLOCK2, D_PROG}) {id_mode, h} = '0;
         else if (busy > 0 && !susp && dq_out == D_SUSPEND) susp = 1;
         else if (susp && dq_out == D_RESUME) susp = 0;
         else if (h == {D_UNLOCK1, D_UNLOCK2, D_ERASE, D_UNLOCK1, D_UNLOCK2}) begin
            if (dq_out == D_CHIP) mem.delete();
            else foreach (mem[k]) if (k[ADDR_W-1:SECT_LSB] == wa[ADDR_W-1:SECT_LSB]) mem[k] = 8'hFF;
            {busy, h} = {BUSY_T, 40'h0};
         end else if (h[2:0] == {D_UNLOCK1, D_UNLOCK2, D_PROG}) begin
            if (!prot[wa[ADDR_W-1:SECT_LSB]] || hv_reset) mem[int'(wa)] = dq_out;
            {busy, h} = {BUSY_T, 40'h0};
         end else if (h[1:0] == {D_UNLOCK1, D_UNLOCK2} && dq_out == D_ID) {id_mode, h} = {1'b1, 40'h0};
         // an unlock byte at a wrong address breaks the sequence
         else if ((dq_out == D_UNLOCK1 && wa[11:0] != UNLOCK1_ADDR[11:0]) ||
            (dq_out == D_UNLOCK2 && wa[11:0] != UNLOCK2_ADDR[11:0])) h = '0;
         else h = {h[3:0], dq_out};
      end
   end
   always @(posedge clk) begin
      if (!reset_n) {busy, id_mode, susp} = '0;
      else if (busy > 0 && !susp) busy--;
      dq_in <= (!ce_n && !oe_n && reset_n) ? rv() : ~dq_in;
   end
   assign done_flag_pin = busy == 0 || susp;
endmodule : flash_dev_model

// ==== tb/parallel_flash_command_decoder_tb.sv ====
`timescale 1ns/1ps
module parallel_flash_command_decoder_tb;
   import flash_host_pkg::*;
   localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
   localparam logic [7:0] PART = 8'hC5; // arbitrary value
   logic sys_clk = 0, resetn = 0, cmd_valid = 0, unprotect_en = 0, err;
   logic [3:0] cmd_op = '0;
   logic [ADDR_W-1:0] cmd_addr = '0, pa, fa;
   logic [7:0] cmd_data = '0, rd, pd;
   wire cmd_ready_r, rsp_valid_r, rsp_err_r, flash_ce_n, flash_oe_n, flash_we_n, top_data_pin, dq_oe_n;
   wire byte_sel_n_r, reset_n_r, hv_reset_r, hv_a9_r, hv_oe, done_flag_pin;
   wire [7:0] rsp_data_r, dq_out, dq_in;
   wire [ADDR_W-2:0] flash_addr;
   int n_mismatch = 0, total_checks = 0, r;
   logic [7:0] sh [int];
   op_e r_ops [3] = '{OP_RESET_SHORT, OP_RESET_LONG, OP_HW_RESET};
   always #5 sys_clk = ~sys_clk;
   flash_host_ctrl u_flash_host_ctrl (.sys_clk, .resetn, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .unprotect_en,
      .cmd_ready_r, .rsp_valid_r, .rsp_err_r, .rsp_data_r, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
      .top_data_pin, .dq_out, .dq_oe_n, .dq_in, .byte_sel_n_r, .reset_n_r, .hv_reset_r, .hv_a9_r, .hv_oe, .done_flag_pin);
   flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash_dev_model (.clk(sys_clk), .ce_n(flash_ce_n),
      .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr), .top_data_pin, .dq_out, .reset_n(reset_n_r),
      .hv_reset(hv_reset_r), .hv_a9(hv_a9_r), .hv_oe, .dq_in, .done_flag_pin);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_rd(logic [ADDR_W-1:0] x);
      return sh.exists(int'(x)) ? sh[int'(x)] : 8'hFF;
   endfunction : exp_rd
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic send(input logic [3:0] op, input logic [ADDR_W-1:0] ad, input logic [7:0] d);
      int n = 0;
      @(posedge sys_clk);
      #1;
      while (cmd_ready_r !== 1'b1 && n < 9000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      {cmd_valid, cmd_op, cmd_addr, cmd_data} = {1'b1, op, ad, d};
      @(posedge sys_clk);
      #1 cmd_valid = 0;
      if (n >= 9000) n_mismatch++;
   endtask : send
   task automatic wait_rsp();
      int n = 0;
      while (rsp_valid_r !== 1'b1 && n < 9000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 9000) n_mismatch++;
      {err, rd} = {rsp_err_r, rsp_data_r};
   endtask : wait_rsp
   task automatic run(input logic [3:0] op, input logic [ADDR_W-1:0] ad, input logic [7:0] d, input logic e);
      send(op, ad, d);
      wait_rsp();
      chk("rsp_err", {7'h0, e}, {7'h0, err});
   endtask : run
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // the host may only drive data while the device output is off
   always @(negedge sys_clk) if (resetn && flash_oe_n === 1'b0) chk("dq_oe_n", 8'h01, {7'h0, dq_oe_n});
   initial begin
      #400_000;
      n_mismatch++;
      close_out();
   end
   initial begin
      r = $urandom(32'hed8d);
      repeat (12) @(posedge sys_clk);
      #1 resetn = 1;
      repeat (2) @(posedge sys_clk);
      #1 chk("byte_sel_n", 8'h00, {7'h0, byte_sel_n_r});
      for (int op = 13; op < 16; op++) run(4'(op), '0, '0, 1'b1);
      for (int i = 0; i < 2; i++) begin
         run(OP_ID_HV, {18'h0, i[0], 1'b0}, '0, 1'b0);
         chk("id_hv", i ? PART : MAKER, rd);
         run(OP_ID_CMD, {18'h0, i[0], 1'b0}, '0, 1'b0);
         chk("id_cmd", i ? PART : MAKER, rd);
      end
      for (int i = 0; i < 6; i++) begin
         {pa, pd, unprotect_en} = {1'b0, 19'($urandom), 8'($urandom), 1'($urandom)};
         if (i == 0) fa = pa;
         run(OP_PROGRAM, pa, pd, 1'b0);
         sh[int'(pa)] = pd;
         run(OP_READ, pa, '0, 1'b0);
         chk("read", exp_rd(pa), rd);
      end
      foreach (r_ops[j]) begin
         run(r_ops[j], 20'h0_0AAA, '0, 1'b0);
         run(OP_READ, fa, '0, 1'b0);
         chk("after_reset", exp_rd(fa), rd);
      end
      {pa, unprotect_en} = {7'h7F, 13'h0123, 1'b0};
      run(OP_PROT_VERIFY, pa, '0, 1'b0);
      chk("prot_off", 8'h00, rd);
      run(OP_PROT_ENABLE, pa, '0, 1'b0);
      run(OP_PROT_VERIFY, pa, '0, 1'b0);
      chk("prot_on", 8'h01, rd);
      for (int u = 0; u < 2; u++) begin
         unprotect_en = u[0];
         run(OP_PROGRAM, pa, 8'h5A, 1'b0);
         run(OP_READ, pa, '0, 1'b0);
         chk("guarded_prog", u ? 8'h5A : 8'hFF, rd);
      end
      send(OP_SECTOR_ERASE, {7'h7F, 13'h0}, '0);
      send(OP_SUSPEND, pa, '0);
      wait_rsp();
      chk("suspend_err", 8'h00, {7'h0, err});
      run(OP_RESUME, pa, '0, 1'b0);
      run(OP_READ, pa, '0, 1'b0);
      chk("sector_erased", 8'hFF, rd);
      run(OP_CHIP_ERASE, '0, '0, 1'b0);
      sh.delete();
      run(OP_READ, fa, '0, 1'b0);
      chk("chip_erased", exp_rd(fa), rd);
      close_out();
   end
endmodule : parallel_flash_command_decoder_tb
